// *** verilog/ftc_pkg.sv ***
// shared constants for the filter tuning and calibration register bank
package ftc_pkg;
    localparam int          FTC_DW          = 24;
    localparam int          FTC_AW          = 5;
    localparam int          FTC_FRAME_BITS  = 32;
    // register offsets
    localparam logic [4:0]  FTC_OFS_CTRL    = 5'h00;
    localparam logic [4:0]  FTC_OFS_SET     = 5'h02;
    localparam logic [4:0]  FTC_OFS_FINE    = 5'h03;
    localparam logic [4:0]  FTC_OFS_STROBE  = 5'h04;
    localparam logic [4:0]  FTC_OFS_PERIOD  = 5'h05;
    localparam logic [4:0]  FTC_OFS_CORR    = 5'h06;
    localparam logic [4:0]  FTC_OFS_SPARE   = 5'h07;
    // field positions
    localparam int          FTC_SRST_BIT    = 5;
    localparam int          FTC_OPB_LSB     = 0;
    localparam int          FTC_DRB_LSB     = 2;
    localparam int          FTC_GAIN_BIT    = 4;
    localparam int          FTC_SKIP_BIT    = 5;
    localparam int          FTC_RANGE_LSB   = 6;
    localparam int          FTC_ZIN_BIT     = 10;
    localparam int          FTC_SET_W       = 11;
    localparam int          FTC_PERIOD_W    = 15;
    localparam int          FTC_CORR_W      = 9;
    // reset values, plus the coarse range maximum
    localparam logic [1:0]  FTC_OPB_RST     = 2'h1;
    localparam logic [1:0]  FTC_DRB_RST     = 2'h2;
    localparam logic [3:0]  FTC_RANGE_RST   = 4'h0;
    localparam logic [3:0]  FTC_RANGE_MAX   = 4'h8;
    localparam logic [3:0]  FTC_FINE_RST    = 4'h0;
    localparam logic [14:0] FTC_PERIOD_RST  = 15'h0000;
    localparam logic [8:0]  FTC_CORR_RST    = 9'h000;
    // identity word; value is arbitrary
    localparam logic [23:0] FTC_ID_VALUE    = 24'h00_5A5A;
endpackage

// *** verilog/ftc_regs.sv ***
// serial-port register bank for filter settings and calibration control
`timescale 1ns/1ps
module ftc_regs
    import ftc_pkg::*;
(
    // clock and reset
    input  wire logic                       sys_clk_i,
    input  wire logic                       nrst_i,
    // serial port pins
    input  wire logic                       spi_sck_i,
    input  wire logic                       spi_sen_n_i,
    input  wire logic                       spi_sdi_i,
    output logic                            spi_sdo_o,
    // bits held in neighbouring registers
    input  wire logic                       cal_override_en_i,
    input  wire logic                       self_test_mode_enable_i,
    input  wire logic                       zin_lsb_select_i,
    // calibration engine
    input  wire logic [3:0]                 cal_fine_result_i,
    input  wire logic [ftc_pkg::FTC_DW-1:0] cal_count_i,
    input  wire logic                       cal_done_i,
    output logic                            cal_start_o,
    output logic                            calibration_self_test_start_o,
    output logic                            cal_busy_o,
    output logic [14:0]                     cal_period_o,
    output logic [ftc_pkg::FTC_DW-1:0]      cal_count_adj_o,
    // analog settings
    output logic [1:0]                      opamp_bias_o,
    output logic [1:0]                      driver_bias_o,
    output logic                            gain_step_select_o,
    output logic                            filter_skip_o,
    output logic [3:0]                      coarse_range_o,
    output logic [1:0]                      zin_select_o,
    output logic [3:0]                      fine_code_o
);
    import ftc_pkg::*;

    logic [2:0]  sck_sync_r;
    logic [1:0]  sen_sync_r;
    logic [1:0]  sdi_sync_r;
    logic        sen_d_r;
    logic [31:0] rx_sh_r;
    logic [5:0]  rx_cnt_r;
    logic [31:0] tx_sh_r;
    logic [4:0]  rd_addr_r;
    logic [10:0] set_r;
    logic [3:0]  fine_r;
    logic [14:0] period_r;
    logic [8:0]  corr_r;
    logic        srst_r;
    logic        wr_stb;
    logic [4:0]  wr_addr;
    logic [23:0] wr_data;
    logic        sck_rise;
    logic        sck_fall;
    logic        sen_fall;
    logic        sen_rise;
    logic [23:0] rd_data;

    // pins are asynchronous to sys_clk; stage 0 feeds only stage 1
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            sck_sync_r <= 3'h0;
            sen_sync_r <= 2'h3;
            sdi_sync_r <= 2'h0;
            sen_d_r    <= 1'b1;
        end else begin
            sck_sync_r <= {sck_sync_r[1:0], spi_sck_i};
            sen_sync_r <= {sen_sync_r[0], spi_sen_n_i};
            sdi_sync_r <= {sdi_sync_r[0], spi_sdi_i};
            sen_d_r    <= sen_sync_r[1];
        end
    end

    assign sck_rise = sck_sync_r[1] & ~sck_sync_r[2];
    assign sck_fall = ~sck_sync_r[1] & sck_sync_r[2];
    assign sen_fall = ~sen_sync_r[1] & sen_d_r;
    assign sen_rise = sen_sync_r[1] & ~sen_d_r;

    // frame: 24 data bits msb first, 5-bit address, 3 ignored bits
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rx_sh_r  <= 32'h0000_0000;
            rx_cnt_r <= 6'h00;
        end else if (sen_fall) begin
            rx_cnt_r <= 6'h00;
        end else if (sck_rise && !sen_sync_r[1]) begin
            rx_sh_r <= {rx_sh_r[30:0], sdi_sync_r[1]};
            if (rx_cnt_r != 6'h3F) begin
                rx_cnt_r <= rx_cnt_r + 6'h01;
            end
        end
    end

    // short or long frames are dropped rather than half-applied
    assign wr_stb  = sen_rise && (rx_cnt_r == 6'(FTC_FRAME_BITS));
    assign wr_addr = rx_sh_r[7:3];
    assign wr_data = rx_sh_r[31:8];

    // soft reset bit is level-held until the host clears it
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rd_addr_r <= 5'h00;
            srst_r    <= 1'b0;
        end else if (wr_stb && wr_addr == FTC_OFS_CTRL) begin
            rd_addr_r <= wr_data[4:0];
            srst_r    <= wr_data[FTC_SRST_BIT];
        end
    end

    // writable storage; only the documented field widths are kept
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i || srst_r) begin
            set_r    <= {1'b0, FTC_RANGE_RST, 1'b0, 1'b0, FTC_DRB_RST, FTC_OPB_RST};
            fine_r   <= FTC_FINE_RST;
            period_r <= FTC_PERIOD_RST;
            corr_r   <= FTC_CORR_RST;
        end else if (wr_stb) begin
            unique case (wr_addr)
                FTC_OFS_SET:    set_r    <= wr_data[FTC_SET_W-1:0];
                FTC_OFS_FINE:   fine_r   <= wr_data[3:0];
                FTC_OFS_PERIOD: period_r <= wr_data[FTC_PERIOD_W-1:0];
                FTC_OFS_CORR:   corr_r   <= wr_data[FTC_CORR_W-1:0];
                default: ;
            endcase
        end
    end

    // strobe holds no data and reads back as zero
    always_comb begin
        rd_data = 24'h00_0000;
        unique case (rd_addr_r)
            FTC_OFS_CTRL:   rd_data = FTC_ID_VALUE;
            FTC_OFS_SET:    rd_data = {13'h0000, set_r};
            FTC_OFS_FINE:   rd_data = {20'h0_0000, fine_r};
            FTC_OFS_PERIOD: rd_data = {9'h000, period_r};
            FTC_OFS_CORR:   rd_data = {15'h0000, corr_r};
            default:        rd_data = 24'h00_0000;
        endcase
    end

    // read data is loaded at frame start and shifted on falling sck
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            tx_sh_r <= 32'h0000_0000;
        end else if (sen_fall) begin
            tx_sh_r <= {rd_data, 8'h00};
        end else if (sck_fall && !sen_sync_r[1]) begin
            tx_sh_r <= {tx_sh_r[30:0], 1'b0};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            spi_sdo_o <= 1'b0;
        end else begin
            spi_sdo_o <= tx_sh_r[31];
        end
    end

    // start pulses; a new strobe while busy restarts the engine
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            cal_start_o                   <= 1'b0;
            calibration_self_test_start_o <= 1'b0;
        end else begin
            cal_start_o                   <= wr_stb && wr_addr == FTC_OFS_STROBE
                                             && !self_test_mode_enable_i;
            calibration_self_test_start_o <= wr_stb && wr_addr == FTC_OFS_STROBE
                                             && self_test_mode_enable_i;
        end
    end

    // start wins over a done arriving in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i || srst_r) begin
            cal_busy_o <= 1'b0;
        end else if (cal_start_o || calibration_self_test_start_o) begin
            cal_busy_o <= 1'b1;
        end else if (cal_done_i) begin
            cal_busy_o <= 1'b0;
        end
    end

    // settings and engine-facing values, all registered
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            opamp_bias_o       <= FTC_OPB_RST;
            driver_bias_o      <= FTC_DRB_RST;
            gain_step_select_o <= 1'b0;
            filter_skip_o      <= 1'b0;
            coarse_range_o     <= FTC_RANGE_RST;
            zin_select_o       <= 2'h0;
            fine_code_o        <= FTC_FINE_RST;
            cal_period_o       <= FTC_PERIOD_RST;
            cal_count_adj_o    <= 24'h00_0000;
        end else begin
            opamp_bias_o       <= set_r[FTC_OPB_LSB +: 2];
            driver_bias_o      <= set_r[FTC_DRB_LSB +: 2];
            gain_step_select_o <= set_r[FTC_GAIN_BIT];
            filter_skip_o      <= set_r[FTC_SKIP_BIT];
            coarse_range_o     <= set_r[FTC_RANGE_LSB +: 4];
            zin_select_o       <= {set_r[FTC_ZIN_BIT], zin_lsb_select_i};
            fine_code_o        <= cal_override_en_i ? fine_r : cal_fine_result_i;
            cal_period_o       <= period_r;
            // sign-extended add, applied the same for every range setting
            cal_count_adj_o    <= cal_count_i + {{15{corr_r[8]}}, corr_r};
        end
    end

    // ---- checks ----
    a_strobe_cal_start: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        wr_stb && wr_addr == FTC_OFS_STROBE && !self_test_mode_enable_i |=> cal_start_o)
        else $error("strobe write did not start calibration");
    a_strobe_self_test: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        wr_stb && wr_addr == FTC_OFS_STROBE && self_test_mode_enable_i
        |=> calibration_self_test_start_o && !cal_start_o)
        else $error("strobe in self-test mode did not start self-test");
    a_start_one_cycle: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        cal_start_o |=> !cal_start_o)
        else $error("start pulse longer than one cycle");
    a_busy_after_start: assert property (@(posedge sys_clk_i) disable iff (!nrst_i || srst_r)
        $rose(cal_start_o) |=> cal_busy_o)
        else $error("busy not raised after start");
    a_fine_override_sel: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        cal_override_en_i |=> fine_code_o == $past(fine_r))
        else $error("override code not applied");
    a_fine_cal_sel: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !cal_override_en_i |=> fine_code_o == $past(cal_fine_result_i))
        else $error("override code used without enable");
    a_corr_signed_add: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        1'b1 |=> cal_count_adj_o == $past(cal_count_i) + {{15{$past(corr_r[8])}}, $past(corr_r)})
        else $error("correction not added as signed value");
    a_period_reset_zero: assert property (@(posedge sys_clk_i)
        !nrst_i |=> period_r == 15'h0000 && corr_r == 9'h000)
        else $error("period or correction not zero after reset");
    a_settings_reset: assert property (@(posedge sys_clk_i)
        !nrst_i ##1 nrst_i |=> opamp_bias_o == 2'h1 && driver_bias_o == 2'h2
        && !gain_step_select_o && !filter_skip_o && coarse_range_o == 4'h0)
        else $error("settings outputs wrong after reset");
    a_zin_combine: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        1'b1 |=> zin_select_o == {$past(set_r[10]), $past(zin_lsb_select_i)})
        else $error("impedance select not combined");
    a_set_upper_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        rd_addr_r == FTC_OFS_SET |-> rd_data[23:11] == 13'h0000)
        else $error("unused settings bits not zero");
    a_strobe_reads_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        rd_addr_r == FTC_OFS_STROBE || rd_addr_r == FTC_OFS_SPARE |-> rd_data == 24'h00_0000)
        else $error("strobe or spare slot not reading zero");

    c_cal_run: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
        cal_start_o ##[1:1000] cal_done_i);
    c_self_test: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
        calibration_self_test_start_o);
    c_set_write: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
        wr_stb && wr_addr == FTC_OFS_SET);
    c_neg_corr: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
        corr_r[8]);
endmodule

// *** testbench/ftc_host_model.sv ***
// host model that drives frames on the serial register port
`timescale 1ns/1ps
module ftc_host_model (
    // clock
    input  wire logic sys_clk_i,
    // serial port pins
    output logic      spi_sck_o,
    output logic      spi_sen_n_o,
    output logic      spi_sdi_o,
    input  wire logic spi_sdo_i
);
    initial begin
        spi_sck_o   = 1'b0;
        spi_sen_n_o = 1'b1;
        spi_sdi_o   = 1'b1;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    // 4-cycle phases just meet the 4-cycle minimum from falling sck to new sdo through the synchroniser and sdo register
    task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
        spi_sen_n_o = 1'b0;
        wait_n(3);
        for (int i = 31; i >= 0; i--) begin
            spi_sdi_o = tx[i];
            wait_n(4);
            spi_sck_o = 1'b1;
            rx[i]     = spi_sdo_i;
            wait_n(4);
            spi_sck_o = 1'b0;
        end
        wait_n(4);
        spi_sen_n_o = 1'b1;
        // idle data line must not keep showing the last bit
        spi_sdi_o   = ~tx[0];
        // long gap also lets register and output stages settle
        wait_n(8);
    endtask
endmodule

// *** testbench/tb_ftc_regs.sv ***
// self-checking bench for the filter tuning and calibration register bank
`timescale 1ns/1ps
module tb_ftc_regs;
    import ftc_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        nrst_i    = 1'b0;
    logic        sck, sen_n, sdi, sdo, ovr, stm, zlsb, done, st, stt, busy;
    logic [3:0]  fres      = 4'h5;
    logic [23:0] cnt       = 24'h00_0100;
    logic [23:0] adj;
    logic [14:0] per;
    logic [1:0]  opb, drb, zin;
    logic        gain, skip;
    logic [3:0]  rng, fine;
    int          n_fail    = 0;
    int          checked   = 0;
    int          n_st      = 0;
    int          n_stt     = 0;
    always #12.5 sys_clk_i = ~sys_clk_i;
    initial begin
        ovr  = 1'b0;
        stm  = 1'b0;
        zlsb = 1'b0;
        done = 1'b0;
    end
    always @(posedge sys_clk_i) begin
        n_st  <= n_st + int'(st);
        n_stt <= n_stt + int'(stt);
    end
    ftc_host_model host_u (.sys_clk_i(sys_clk_i), .spi_sck_o(sck), .spi_sen_n_o(sen_n),
        .spi_sdi_o(sdi), .spi_sdo_i(sdo));
    ftc_regs dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .spi_sck_i(sck),
        .spi_sen_n_i(sen_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .cal_override_en_i(ovr),
        .self_test_mode_enable_i(stm), .zin_lsb_select_i(zlsb), .cal_fine_result_i(fres),
        .cal_count_i(cnt), .cal_done_i(done), .cal_start_o(st),
        .calibration_self_test_start_o(stt), .cal_busy_o(busy), .cal_period_o(per),
        .cal_count_adj_o(adj), .opamp_bias_o(opb), .driver_bias_o(drb),
        .gain_step_select_o(gain), .filter_skip_o(skip), .coarse_range_o(rng),
        .zin_select_o(zin), .fine_code_o(fine));
    task automatic give_verdict();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        logic [31:0] rx;
        host_u.frame({d, a, 3'h0}, rx);
    endtask
    // read: latch the address through offset 00, then shift the data out
    task automatic rdchk(input logic [4:0] a, input logic [23:0] exp);
        logic [31:0] rx;
        wr(FTC_OFS_CTRL, {19'h0_0000, a});
        host_u.frame(32'h0000_0000, rx);
        chk(rx[31:8], exp, "read back");
    endtask
    function automatic logic [23:0] outs();
        return {12'h000, zin, rng, skip, gain, drb, opb};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk_i);
        n_fail++;
        give_verdict();
    end
    initial begin
        logic [1:0]  b;
        logic [23:0] d;
        tick(20);
        chk(outs(), 24'h00_0009, "settings reset");
        chk({9'h000, per}, 24'h00_0000, "period reset");
        nrst_i = 1'b1;
        tick(3);
        rdchk(FTC_OFS_SET, 24'h00_0009);
        rdchk(FTC_OFS_FINE, 24'h00_0000);
        rdchk(FTC_OFS_PERIOD, 24'h00_0000);
        rdchk(FTC_OFS_CORR, 24'h00_0000);
        $display("test reset values done");
        for (int i = 0; i <= 8; i++) begin
            b    = i[1:0];
            zlsb = i[1];
            d    = {13'h0000, i[0], i[3:0], i[0], ~i[0], ~b, b};
            wr(FTC_OFS_SET, d);
            chk(outs(), {12'h000, i[0], i[1], d[9:0]}, "settings");
            rdchk(FTC_OFS_SET, d);
        end
        wr(FTC_OFS_SET, 24'hFF_FFFF);
        rdchk(FTC_OFS_SET, 24'h00_07FF);
        wr(5'h01, 24'h00_0000);
        wr(FTC_OFS_SPARE, 24'hFF_FFFF);
        rdchk(FTC_OFS_SPARE, 24'h00_0000);
        rdchk(FTC_OFS_SET, 24'h00_07FF);
        $display("test settings done");
        wr(FTC_OFS_FINE, 24'hFF_FFFB);
        chk({20'h0_0000, fine}, 24'h00_0005, "fine no override");
        ovr = 1'b1;
        tick(2);
        chk({20'h0_0000, fine}, 24'h00_000B, "fine override");
        rdchk(FTC_OFS_FINE, 24'h00_000B);
        $display("test fine code done");
        wr(FTC_OFS_PERIOD, 24'hFF_FFFF);
        chk({9'h000, per}, 24'h00_7FFF, "period max");
        wr(FTC_OFS_PERIOD, 24'h00_61A8);
        chk({9'h000, per}, 24'h00_61A8, "period");
        rdchk(FTC_OFS_PERIOD, 24'h00_61A8);
        $display("test period done");
        wr(FTC_OFS_CORR, 24'hFF_FFFF);
        chk(adj, 24'h00_00FF, "minus one");
        rdchk(FTC_OFS_CORR, 24'h00_01FF);
        cnt = 24'h00_0000;
        tick(2);
        chk(adj, 24'hFF_FFFF, "sign extend");
        wr(FTC_OFS_CORR, 24'h00_00FF);
        cnt = 24'h80_0001;
        tick(2);
        chk(adj, 24'h80_0100, "plus 255");
        $display("test correction done");
        n_st  = 0;
        n_stt = 0;
        wr(FTC_OFS_STROBE, 24'h00_0000);
        chk(24'(n_st * 16 + n_stt), 24'h00_0010, "cal start pulse");
        chk({23'h00_0000, busy}, 24'h00_0001, "busy set");
        done = 1'b1;
        tick(1);
        done = 1'b0;
        tick(2);
        chk({23'h00_0000, busy}, 24'h00_0000, "busy clear");
        stm   = 1'b1;
        tick(1);
        n_st  = 0;
        n_stt = 0;
        wr(FTC_OFS_STROBE, 24'hAB_CDEF);
        chk(24'(n_st * 16 + n_stt), 24'h00_0001, "self-test pulse");
        rdchk(FTC_OFS_STROBE, 24'h00_0000);
        $display("test strobe done");
        // soft reset holds settings at defaults until bit 5 is cleared again
        zlsb = 1'b0;
        wr(FTC_OFS_CTRL, 24'h00_0020);
        chk(outs(), 24'h00_0009, "soft reset");
        rdchk(FTC_OFS_PERIOD, 24'h00_0000);
        $display("test soft reset done");
        give_verdict();
    end
endmodule
